// [inc/bridge_pwm_pkg.sv]
// constants and carrier types for the full-bridge pwm steering block
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port
package bridge_pwm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DUTY_OFS = 8'h04;
    localparam logic [7:0] DIR_OFS = 8'h08;
    localparam logic [7:0] PER_OFS = 8'h0C;
    localparam logic [7:0] PORT_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam int STEER_LO = 6;
    localparam int DLSB_LO = 4;
    localparam int MODE_LO = 2;
    localparam int AC_LOW_BIT = 1;
    localparam int BD_LOW_BIT = 0;
    localparam int STAT_MOD_BIT = 10;
    localparam int STAT_PIN_LO = 12;
    localparam logic [1:0] STEER_SINGLE = 2'h0;
    localparam logic [1:0] STEER_HALF = 2'h2;
    localparam logic [1:0] STEER_FWD = 2'h1;
    localparam logic [1:0] STEER_REV = 2'h3;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [3:0] DIR_RST = 4'hF;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam int CLK_HZ = 20_000_000;
    localparam int CARRIER_HZ = 120_000;
    localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ;
    localparam logic [7:0] PER_RST = 8'(CARRIER_CYC / 4 - 1);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe_n;
    } pin_drive_s;

    typedef struct packed {
        logic [9:0] cnt;
        logic mod;
        logic wrap;
    } pwm_state_s;
endpackage

// [logic/axil_slave.sv]
// AXI4-Lite slave front end, one write and one read at a time
// assumes the parent decodes addresses and returns read data combinationally
`timescale 1ns/1ns
`default_nettype none
module axil_slave (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [bridge_pwm_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [bridge_pwm_pkg::DATA_W-1:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [bridge_pwm_pkg::ADDR_W-1:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [bridge_pwm_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic wr_en_o,
    output logic [bridge_pwm_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [bridge_pwm_pkg::DATA_W-1:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_ok_i,
    input wire logic [bridge_pwm_pkg::DATA_W-1:0] rd_data_i,
    input wire logic rd_ok_i
);
    import bridge_pwm_pkg::*;

    logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic wr_go, nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid, ar_take;

    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign nxt_aw_got = !wr_go && (aw_got_ff || (awvalid_i && awready_ff));
    assign nxt_w_got = !wr_go && (w_got_ff || (wvalid_i && wready_ff));
    assign nxt_bvalid = wr_go || (bvalid_ff && !bready_i);
    assign ar_take = arvalid_i && arready_ff;
    assign nxt_rvalid = ar_take || (rvalid_ff && !rready_i);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= !nxt_aw_got && !nxt_bvalid && !wr_go;
            wready_ff <= !nxt_w_got && !nxt_bvalid && !wr_go;
            bvalid_ff <= nxt_bvalid;
            if (wr_go) begin
                bresp_ff <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_addr_o <= '0;
            wr_data_o <= '0;
            wr_strb_o <= 4'h0;
        end else begin
            if (awvalid_i && awready_ff) begin
                wr_addr_o <= awaddr_i;
            end
            if (wvalid_i && wready_ff) begin
                wr_data_o <= wdata_i;
                wr_strb_o <= wstrb_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_ok_i ? rd_data_i : '0;
                rresp_ff <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign wr_en_o = wr_go;
    assign awready_o = awready_ff;
    assign wready_o = wready_ff;
    assign bvalid_o = bvalid_ff;
    assign bresp_o = bresp_ff;
    assign arready_o = arready_ff;
    assign rvalid_o = rvalid_ff;
    assign rdata_o = rdata_ff;
    assign rresp_o = rresp_ff;

    chk_bvalid_hold: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        bvalid_ff && !bready_i |=> bvalid_ff && $stable(bresp_ff))
        else $error("write response dropped before bready");
endmodule
`default_nettype wire

// [logic/full_bridge_pwm_steering.sv]
// pwm block that steers one modulated waveform onto four bridge outputs
// assumes AXI4-Lite master on clk_sys_i and external gate drivers on the pins
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - forward: output A held active, D modulated, B and C released
// - reverse: output C held active, B modulated, A and D released
// - coast: all four outputs released through the direction register
// - brake: B and C driven high as port pins, A and D released
// - control bits 7:6 pick single output, half-bridge, forward or reverse full-bridge steering
// - control bits 1:0 pick active level of A/C and B/D pairs
// - a direction bit set to one releases that pin
// - duty follows the upper duty register, from zero to full scale
// - can make a 50 percent square carrier near 120 kHz
// - carrier on the pwm output pin is gated by its direction bit
// - duty is 10 bits, low two bits in control bits 5:4
module full_bridge_pwm_steering (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [bridge_pwm_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [bridge_pwm_pkg::DATA_W-1:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [bridge_pwm_pkg::ADDR_W-1:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [bridge_pwm_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    input wire logic [3:0] bridge_in_i,
    output bridge_pwm_pkg::pin_drive_s bridge_o
);
    import bridge_pwm_pkg::*;

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [DATA_W-1:0] rd_data;
    logic rd_ok;

    axil_slave u_bus (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .awaddr_i(awaddr_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .bresp_o(bresp_o),
        .arvalid_i(arvalid_i),
        .arready_o(arready_o),
        .araddr_i(araddr_i),
        .rvalid_o(rvalid_o),
        .rready_i(rready_i),
        .rdata_o(rdata_o),
        .rresp_o(rresp_o),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_ok_i(wr_ok),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    // registers: control, upper duty, pin direction, period, port level
    logic [7:0] bridge_pwm_control_ff;
    logic [7:0] duty_cycle_upper_ff;
    logic [3:0] pin_direction_reg_ff;
    logic [7:0] period_ff;
    logic [3:0] port_level_ff;
    logic lane0;

    assign lane0 = wr_en && wr_strb[0];
    assign wr_ok = (wr_addr == CTRL_OFS) || (wr_addr == DUTY_OFS)
        || (wr_addr == DIR_OFS) || (wr_addr == PER_OFS)
        || (wr_addr == PORT_OFS) || (wr_addr == STAT_OFS);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bridge_pwm_control_ff <= CTRL_RST;
            duty_cycle_upper_ff <= DUTY_RST;
            pin_direction_reg_ff <= DIR_RST;
            period_ff <= PER_RST;
            port_level_ff <= PORT_RST;
        end else if (lane0) begin
            unique case (wr_addr)
                CTRL_OFS: bridge_pwm_control_ff <= wr_data[7:0];
                DUTY_OFS: duty_cycle_upper_ff <= wr_data[7:0];
                DIR_OFS: pin_direction_reg_ff <= wr_data[3:0];
                PER_OFS: period_ff <= wr_data[7:0];
                PORT_OFS: port_level_ff <= wr_data[3:0];
                default: ;
            endcase
        end
    end

    // field views of the control register
    logic [1:0] steer;
    logic pwm_on;
    logic ac_low;
    logic bd_low;
    logic [9:0] duty10;

    assign steer = bridge_pwm_control_ff[STEER_LO +: 2];
    assign pwm_on = bridge_pwm_control_ff[MODE_LO +: 2] == MODE_PWM;
    assign ac_low = bridge_pwm_control_ff[AC_LOW_BIT];
    assign bd_low = bridge_pwm_control_ff[BD_LOW_BIT];
    assign duty10 = {duty_cycle_upper_ff, bridge_pwm_control_ff[DLSB_LO +: 2]};

    pwm_state_s pst;

    pwm_core u_core (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(pwm_on),
        .period_i(period_ff),
        .duty_i(duty10),
        .st_o(pst)
    );

    // pin inputs: three flops, a change is taken once the last two agree
    logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_seen_ff;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_s3_ff <= 4'h0;
            pin_seen_ff <= 4'h0;
        end else begin
            pin_s1_ff <= bridge_in_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            // per pin, so a floating pin cannot freeze the steady ones
            pin_seen_ff <= (pin_s2_ff & pin_s3_ff)
                | (pin_seen_ff & (pin_s2_ff | pin_s3_ff));
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_data = '0;
        unique case (araddr_i)
            CTRL_OFS: rd_data[7:0] = bridge_pwm_control_ff;
            DUTY_OFS: rd_data[7:0] = duty_cycle_upper_ff;
            DIR_OFS: rd_data[3:0] = pin_direction_reg_ff;
            PER_OFS: rd_data[7:0] = period_ff;
            PORT_OFS: rd_data[3:0] = port_level_ff;
            STAT_OFS: begin
                rd_data[9:0] = pst.cnt;
                rd_data[STAT_MOD_BIT] = pst.mod;
                rd_data[STAT_PIN_LO +: 4] = pin_seen_ff;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // steering: which pins the pwm claims, which it drives, raw active level
    logic [3:0] claim;
    logic [3:0] use_v;
    logic [3:0] act;
    logic [3:0] pol_low;

    assign pol_low = {bd_low, ac_low, bd_low, ac_low};

    always_comb begin
        claim = 4'h0;
        use_v = 4'h0;
        act = 4'h0;
        unique case (steer)
            STEER_SINGLE: begin
                claim[PIN_A] = 1'b1;
                use_v[PIN_A] = 1'b1;
                act[PIN_A] = pst.mod;
            end
            STEER_HALF: begin
                claim[PIN_A] = 1'b1;
                claim[PIN_B] = 1'b1;
                use_v[PIN_A] = 1'b1;
                use_v[PIN_B] = 1'b1;
                act[PIN_A] = pst.mod;
                act[PIN_B] = !pst.mod;
            end
            STEER_FWD: begin
                claim = 4'hF;
                use_v[PIN_A] = 1'b1;
                use_v[PIN_D] = 1'b1;
                act[PIN_A] = 1'b1;
                act[PIN_D] = pst.mod;
            end
            STEER_REV: begin
                claim = 4'hF;
                use_v[PIN_C] = 1'b1;
                use_v[PIN_B] = 1'b1;
                act[PIN_C] = 1'b1;
                act[PIN_B] = pst.mod;
            end
        endcase
    end

    // unused full-bridge legs are released so no leg can short on its own
    logic [3:0] nxt_level;
    logic [3:0] nxt_oe_n;
    logic [3:0] level_ff;
    logic [3:0] oe_n_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic owned;
            assign owned = pwm_on && claim[gi];
            assign nxt_level[gi] = owned ? (act[gi] ^ pol_low[gi]) : port_level_ff[gi];
            assign nxt_oe_n[gi] = pin_direction_reg_ff[gi] || (owned && !use_v[gi]);
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_ff <= 4'h0;
            oe_n_ff <= 4'hF;
        end else begin
            level_ff <= nxt_level;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign bridge_o = '{level: level_ff, oe_n: oe_n_ff};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_fwd_a_active: assert property (
        pwm_on && steer == STEER_FWD && !pin_direction_reg_ff[PIN_A]
        |=> !oe_n_ff[PIN_A] && level_ff[PIN_A] == !$past(ac_low))
        else $error("forward output A not held active");

    chk_fwd_d_mod: assert property (
        pwm_on && steer == STEER_FWD && !pin_direction_reg_ff[PIN_D]
        |=> !oe_n_ff[PIN_D] && level_ff[PIN_D] == ($past(pst.mod) ^ $past(bd_low)))
        else $error("forward output D not modulated");

    chk_fwd_bc_free: assert property (
        pwm_on && steer == STEER_FWD
        |=> oe_n_ff[PIN_B] && oe_n_ff[PIN_C])
        else $error("forward drives B or C");

    chk_rev_c_active: assert property (
        pwm_on && steer == STEER_REV && !pin_direction_reg_ff[PIN_C]
        |=> !oe_n_ff[PIN_C] && level_ff[PIN_C] == !$past(ac_low))
        else $error("reverse output C not held active");

    chk_rev_b_mod: assert property (
        pwm_on && steer == STEER_REV && !pin_direction_reg_ff[PIN_B]
        |=> level_ff[PIN_B] == ($past(pst.mod) ^ $past(bd_low)) && oe_n_ff[PIN_A]
            && oe_n_ff[PIN_D])
        else $error("reverse output B wrong or A, D driven");

    chk_coast_free: assert property (
        pin_direction_reg_ff == 4'hF [*2] |-> oe_n_ff == 4'hF)
        else $error("coast leaves a pin driven");

    chk_brake_bc: assert property (
        !pwm_on && pin_direction_reg_ff == 4'h9 && port_level_ff[2:1] == 2'h3
        |=> level_ff[2:1] == 2'h3 && oe_n_ff == 4'h9)
        else $error("brake does not drive B and C high");

    chk_carrier_gate: assert property (
        pwm_on && steer == STEER_SINGLE && $rose(pin_direction_reg_ff[PIN_A])
        |-> ##1 oe_n_ff[PIN_A] [*2])
        else $error("carrier not removed when pin released");

    chk_dir_release: assert property (
        pin_direction_reg_ff != 4'h0 |=> (oe_n_ff & $past(pin_direction_reg_ff))
            == $past(pin_direction_reg_ff))
        else $error("released pin still driven");

    chk_wrap_period: assert property (
        pst.wrap && pwm_on |-> pst.cnt == 10'h000)
        else $error("wrap without counter restart");
endmodule
`default_nettype wire

// [logic/pwm_core.sv]
// 10-bit pwm timebase and duty compare
// assumes period and duty come from registers on the same clock
`timescale 1ns/1ns
`default_nettype none
module pwm_core (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [7:0] period_i,
    input wire logic [9:0] duty_i,
    output bridge_pwm_pkg::pwm_state_s st_o
);
    import bridge_pwm_pkg::*;

    logic [9:0] cnt_ff;
    logic [9:0] duty_buf_ff;
    logic [7:0] per_buf_ff;
    logic mod_ff;
    logic wrap_ff;
    logic [9:0] nxt_cnt;
    logic [9:0] nxt_duty;
    logic end_of_period;

    assign end_of_period = (cnt_ff == {per_buf_ff, 2'h3});
    assign nxt_cnt = (end_of_period || !en_i) ? 10'h000 : cnt_ff + 10'h001;
    // the first count of a period must see the duty that is reloaded with it
    assign nxt_duty = (end_of_period || !en_i) ? duty_i : duty_buf_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 10'h000;
            wrap_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            wrap_ff <= en_i && end_of_period;
        end
    end

    // duty and period reload only at the wrap or while disabled so a write never glitches a pulse
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            duty_buf_ff <= 10'h000;
            per_buf_ff <= PER_RST;
        end else if (end_of_period || !en_i) begin
            duty_buf_ff <= duty_i;
            per_buf_ff <= period_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_ff <= 1'b0;
        end else begin
            mod_ff <= en_i && (nxt_cnt < nxt_duty);
        end
    end

    assign st_o = '{cnt: cnt_ff, mod: mod_ff, wrap: wrap_ff};

    logic [10:0] high_cnt_ff;
    logic full_per_ff;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_cnt_ff <= 11'h000;
            full_per_ff <= 1'b0;
        end else begin
            high_cnt_ff <= end_of_period ? 11'h000 : high_cnt_ff + 11'(mod_ff);
            full_per_ff <= en_i && (full_per_ff || end_of_period);
        end
    end

    chk_duty_count: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (en_i && full_per_ff && end_of_period && $stable(duty_buf_ff)
            && duty_buf_ff <= {per_buf_ff, 2'h3})
        |-> (high_cnt_ff + 11'(mod_ff) == {1'b0, duty_buf_ff} + 11'(cnt_ff == 10'h000)
             || high_cnt_ff + 11'(mod_ff) == {1'b0, duty_buf_ff}))
        else $error("high time differs from duty");

    chk_count_bound: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        en_i |-> cnt_ff <= {per_buf_ff, 2'h3})
        else $error("counter passed its period");
endmodule
`default_nettype wire

// [test/bridge_gate_model.sv]
// gate-driver model of the four full-bridge legs
// assumes pin_drive_s from the package; released gate inputs float
`timescale 1ns/1ns
`default_nettype none
module bridge_gate_model (
    input wire logic clk_sys_i,
    input wire bridge_pwm_pkg::pin_drive_s drv_i,
    output logic [3:0] pin_o
);
    import bridge_pwm_pkg::*;
    logic tgl_ff = 1'b0;
    always_ff @(posedge clk_sys_i) begin
        tgl_ff <= !tgl_ff;
    end
    // a floating input must not look like a held level, so it changes every cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_o[i] = drv_i.oe_n[i] ? (tgl_ff ^ i[0]) : drv_i.level[i];
        end
    end
endmodule
`default_nettype wire

// [test/full_bridge_pwm_steering_tb_top.sv]
// self-checking bench: AXI4-Lite driver, gate-driver model, queued expectations
// assumes a 50 ns clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module full_bridge_pwm_steering_tb_top;
    import bridge_pwm_pkg::*;
    logic clk_sys_i = 0, rst_n_i = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, win = 0, win_d = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0, pins;
    logic [1:0] bresp, rresp;
    pin_drive_s drv;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [23:0] pq[$];
    logic [23:0] pe;
    logic [1:0] be;
    logic [33:0] re;
    int error_cnt = 0, n_tests = 0, hi = 0, mp = 0;
    full_bridge_pwm_steering dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
        .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
        .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
        .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
        .rresp_o(rresp), .bridge_in_i(pins), .bridge_o(drv));
    bridge_gate_model gate (.clk_sys_i(clk_sys_i), .drv_i(drv), .pin_o(pins));
    initial begin
        forever #25 clk_sys_i = !clk_sys_i;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit aw_d, w_d;
        aw_d = 0;
        w_d = 0;
        bq.push_back(er);
        @(posedge clk_sys_i);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        wstrb <= s;
        bready <= 1;
        while (!(aw_d && w_d)) begin
            @(posedge clk_sys_i);
            if (awvalid && awready) begin
                aw_d = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                w_d = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk_sys_i); while (!bvalid);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge clk_sys_i);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        do @(posedge clk_sys_i); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge clk_sys_i);
        rready <= 0;
    endtask
    // window of n cycles counting high cycles of pin m, then pins are compared
    task automatic chk(input logic [3:0] oe, msk, lv, input int m, n, h);
        pq.push_back({oe, msk, lv, 12'(h)});
        @(posedge clk_sys_i);
        mp <= m;
        win <= 1;
        repeat (n) @(posedge clk_sys_i);
        win <= 0;
        @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        if (rst_n_i) begin
            if (bvalid && bready) begin
                be = bq.pop_front();
                `CMP(bresp, be)
            end
            if (rvalid && rready) begin
                re = rq.pop_front();
                `CMP({rresp, rdata}, re)
            end
            // only cycles in which the pin is driven high count
            if (win) hi += int'(drv.level[mp] && !drv.oe_n[mp]);
            if (!win && win_d) begin
                pe = pq.pop_front();
                `CMP({drv.oe_n, drv.level & pe[19:16], 12'(hi)}, {pe[23:20], pe[15:0]})
                hi = 0;
            end
            win_d = win;
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        error_cnt++;
        wrap_up();
    end
    initial begin
        int p, n, d, lo;
        logic [1:0] st;
        logic [7:0] c;
        void'($urandom(37));
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1;
        rd(CTRL_OFS, {RESP_OKAY, 24'h0, CTRL_RST});
        rd(DUTY_OFS, {RESP_OKAY, 24'h0, DUTY_RST});
        rd(DIR_OFS, {RESP_OKAY, 28'h0, DIR_RST});
        rd(PER_OFS, {RESP_OKAY, 24'h0, PER_RST});
        rd(PORT_OFS, {RESP_OKAY, 28'h0, PORT_RST});
        chk(4'hF, 4'hF, 4'h0, 0, 1, 0);
        wr(8'h18, 32'hFF, 4'hF, RESP_SLVERR);
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(STAT_OFS, 32'hFF, 4'hF, RESP_OKAY);
        wr(CTRL_OFS, 32'hFF, 4'hE, RESP_OKAY);
        rd(CTRL_OFS, {RESP_OKAY, 32'h0});
        // carrier: reset period gives 164 clocks, 121.95 kHz, duty 82 is half
        wr(DUTY_OFS, 32'h14, 4'h1, RESP_OKAY);
        wr(CTRL_OFS, 32'h2C, 4'h1, RESP_OKAY);
        wr(DIR_OFS, 32'h0, 4'h1, RESP_OKAY);
        repeat (400) @(posedge clk_sys_i);
        chk(4'h0, 4'h0, 4'h0, 0, 328, 164);
        wr(DIR_OFS, 32'h1, 4'h1, RESP_OKAY);
        chk(4'h1, 4'h0, 4'h0, 0, 1, 0);
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr(DIR_OFS, 32'hF, 4'h1, RESP_OKAY);
                chk(4'hF, 4'h0, 4'h0, 0, 1, 0);
                repeat (70) @(posedge clk_sys_i);
                p = $urandom_range(15, 3);
                n = (p + 1) * 4;
                d = (k == 0) ? 0 : (k == 1) ? $urandom_range(n - 1, 1) : 1023;
                st = (m == 1) ? STEER_REV : STEER_FWD;
                c = {st, 2'(d), MODE_PWM, (m == 2) ? 2'b11 : 2'b00};
                wr(PER_OFS, 32'(p), 4'h1, RESP_OKAY);
                wr(DUTY_OFS, 32'(d >> 2), 4'h1, RESP_OKAY);
                wr(CTRL_OFS, 32'(c), 4'h1, RESP_OKAY);
                rd(CTRL_OFS, {RESP_OKAY, 24'h0, c});
                wr(DIR_OFS, 32'h0, 4'h1, RESP_OKAY);
                // the old period may be the 164-clock carrier: let it wrap, then two more
                repeat (2 * n + 170) @(posedge clk_sys_i);
                lo = (d < n) ? d : n;
                if (m == 1)
                    chk(4'b1001, 4'h4, 4'h4, 1, 2 * n, 2 * lo);
                else if (m == 0)
                    chk(4'b0110, 4'h1, 4'h1, 3, 2 * n, 2 * lo);
                else
                    chk(4'b0110, 4'h1, 4'h0, 3, 2 * n, 2 * (n - lo));
            end
        end
        wr(CTRL_OFS, 32'h0, 4'h1, RESP_OKAY);
        wr(PORT_OFS, 32'h6, 4'h1, RESP_OKAY);
        wr(DIR_OFS, 32'h9, 4'h1, RESP_OKAY);
        chk(4'b1001, 4'h6, 4'h6, 0, 1, 0);
        rd(STAT_OFS, {RESP_OKAY, 32'h0000_6000});
        wrap_up();
    end
endmodule
`default_nettype wire
